// *** pkg/cbbc_pkg.sv ***
// constants, types and encodings for the branch-on-carry / clear-bit executor
package cbbc_pkg;

  // opcode patterns
  localparam logic [7:0]  OPC_BRANCH_ON_CARRY = 8'hE2;
  localparam logic [3:0]  OPC_CLEAR_BIT       = 4'h9;
  localparam logic [15:0] INSTR_NOP           = 16'h0000;

  // instruction word field positions
  localparam int OPC_HI     = 15;
  localparam int OPC_LO     = 8;
  localparam int NIB_LO     = 12;
  localparam int BIT_HI     = 11;
  localparam int BIT_LO     = 9;
  localparam int ABIT       = 8;
  localparam int LIT_HI     = 7;
  localparam int DATA_W     = 8;
  localparam int BANK_W     = 4;
  localparam int ADDR_W     = 12;

  // access bank split and indexed-literal window
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_PAGE = 4'hF;
  localparam logic [7:0]        INDEXED_LIMIT  = 8'h5F;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    QP1 = 2'b00,
    QP2 = 2'b01,
    QP3 = 2'b10,
    QP4 = 2'b11
  } quarter_t;

  // instruction-cycle state: executing or idling after a taken branch
  typedef enum logic {
    ST_EXEC = 1'b0,
    ST_IDLE = 1'b1
  } exec_state_t;

  // data memory request, one word wide
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

endpackage

// *** rtl/bank_addr_resolve.sv ***
// resolves an 8-bit register field to a 12-bit data-memory address
`timescale 1ns/1ps
module bank_addr_resolve (
  input  wire logic [7:0]                   reg_field,
  input  wire logic                         bank_flag,
  input  wire logic [cbbc_pkg::BANK_W-1:0]  bank_select_register,
  input  wire logic                         ext_en,
  input  wire logic [cbbc_pkg::ADDR_W-1:0]  index_base,
  output logic      [cbbc_pkg::ADDR_W-1:0]  addr
);

  // indexed mode wins over the plain access bank for low addresses
  always_comb begin
    if (bank_flag) begin
      addr = {bank_select_register, reg_field};
    end else if (ext_en && (reg_field <= cbbc_pkg::INDEXED_LIMIT)) begin
      addr = index_base + {{(cbbc_pkg::ADDR_W-8){1'b0}}, reg_field};
    end else if (reg_field < cbbc_pkg::ACCESS_SPLIT) begin
      addr = {cbbc_pkg::ACCESS_LO_PAGE, reg_field};
    end else begin
      addr = {cbbc_pkg::ACCESS_HI_PAGE, reg_field};
    end
  end

endmodule // bank_addr_resolve

// *** rtl/carry_branch_bit_clear_exec.sv ***
// decode and execute of branch-on-carry and clear-register-bit, one clock per quarter
`timescale 1ns/1ps
module carry_branch_bit_clear_exec #(
  parameter int PC_W = 21
) (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic [15:0]                   instr,
  input  wire logic                          carry,
  input  wire logic [PC_W-1:0]               pc_next,
  input  wire logic [cbbc_pkg::BANK_W-1:0]   bank_select_register,
  input  wire logic                          ext_en,
  input  wire logic [cbbc_pkg::ADDR_W-1:0]   index_base,
  input  wire logic [cbbc_pkg::DATA_W-1:0]   mem_rdata,
  output cbbc_pkg::quarter_t                 quarter_q,
  output cbbc_pkg::exec_state_t              state_q,
  output logic                               pc_wr_q,
  output logic      [PC_W-1:0]               pc_target_q,
  output cbbc_pkg::mem_req_t                 mem_q
);

  logic [15:0]                 instr_q;
  logic                        taken_q;
  logic [cbbc_pkg::DATA_W-1:0] data_q;
  logic                        is_bc;
  logic                        is_bcf;
  logic                        raw_bcf;
  logic [cbbc_pkg::ADDR_W-1:0] res_addr;
  logic [cbbc_pkg::DATA_W-1:0] clr_mask;
  logic [PC_W-1:0]             offs_ext;
  logic [PC_W-1:0]             target_d;

  assign is_bc   = (instr_q[cbbc_pkg::OPC_HI:cbbc_pkg::OPC_LO] == cbbc_pkg::OPC_BRANCH_ON_CARRY);
  assign is_bcf  = (instr_q[cbbc_pkg::OPC_HI:cbbc_pkg::NIB_LO] == cbbc_pkg::OPC_CLEAR_BIT);
  assign raw_bcf = (instr[cbbc_pkg::OPC_HI:cbbc_pkg::NIB_LO] == cbbc_pkg::OPC_CLEAR_BIT);

  // signed offset doubled, sign carried up to the counter width
  assign offs_ext = {{(PC_W-9){instr_q[cbbc_pkg::LIT_HI]}}, instr_q[cbbc_pkg::LIT_HI:0], 1'b0};
  assign target_d = pc_next + offs_ext;

  // one-hot bit mask from the 3-bit index, one comparator per bit
  for (genvar i = 0; i < cbbc_pkg::DATA_W; i++) begin : g_mask
    assign clr_mask[i] = (instr_q[cbbc_pkg::BIT_HI:cbbc_pkg::BIT_LO] == 3'(i));
  end

  // address is resolved from the raw word so the read can go out in Q2
  bank_addr_resolve u_resolve (
    .reg_field            (instr[cbbc_pkg::LIT_HI:0]),
    .bank_flag            (instr[cbbc_pkg::ABIT]),
    .bank_select_register (bank_select_register),
    .ext_en               (ext_en),
    .index_base           (index_base),
    .addr                 (res_addr)
  );

  // quarter phase counter, free running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quarter_q <= cbbc_pkg::QP1;
    end else begin
      unique case (quarter_q)
        cbbc_pkg::QP1: quarter_q <= cbbc_pkg::QP2;
        cbbc_pkg::QP2: quarter_q <= cbbc_pkg::QP3;
        cbbc_pkg::QP3: quarter_q <= cbbc_pkg::QP4;
        cbbc_pkg::QP4: quarter_q <= cbbc_pkg::QP1;
      endcase
    end
  end

  // a taken branch turns the following cycle into an idle one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= cbbc_pkg::ST_EXEC;
    end else if (quarter_q == cbbc_pkg::QP4) begin
      unique case (state_q)
        cbbc_pkg::ST_EXEC: state_q <= taken_q ? cbbc_pkg::ST_IDLE : cbbc_pkg::ST_EXEC;
        cbbc_pkg::ST_IDLE: state_q <= cbbc_pkg::ST_EXEC;
      endcase
    end
  end

  // decode latch; the idle cycle sees a no-op so the prefetched word is flushed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_q <= cbbc_pkg::INSTR_NOP;
    end else if (quarter_q == cbbc_pkg::QP1) begin
      instr_q <= (state_q == cbbc_pkg::ST_EXEC) ? instr : cbbc_pkg::INSTR_NOP;
    end
  end

  // carry sampled once, at the end of Q2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      taken_q <= 1'b0;
    end else if (quarter_q == cbbc_pkg::QP2) begin
      taken_q <= is_bc && carry;
    end else if (quarter_q == cbbc_pkg::QP4) begin
      taken_q <= 1'b0;
    end
  end

  // counter written during Q4 of the branch cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_wr_q     <= 1'b0;
      pc_target_q <= '0;
    end else if (quarter_q == cbbc_pkg::QP3) begin
      pc_wr_q <= taken_q;
      if (taken_q) begin
        // target is pc_next plus twice n
        pc_target_q <= target_d;
      end
    end else begin
      pc_wr_q <= 1'b0;
    end
  end

  // read in Q2, modify in Q3, write in Q4; no flag output exists at all
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_q  <= '0;
      data_q <= '0;
    end else begin
      unique case (quarter_q)
        cbbc_pkg::QP1: begin
          mem_q.rd <= (state_q == cbbc_pkg::ST_EXEC) && raw_bcf;
          if ((state_q == cbbc_pkg::ST_EXEC) && raw_bcf) begin
            mem_q.addr <= res_addr;
          end
        end
        cbbc_pkg::QP2: begin
          mem_q.rd <= 1'b0;
          data_q   <= mem_rdata;
        end
        cbbc_pkg::QP3: begin
          mem_q.wr <= is_bcf;
          // only the selected bit goes low
          mem_q.wdata <= data_q & ~clr_mask;
        end
        cbbc_pkg::QP4: begin
          mem_q.wr <= 1'b0;
        end
      endcase
    end
  end

  // ---- assertions ----

  sequence s_rmw;
    mem_q.rd ##1 !mem_q.rd && !mem_q.wr ##1 mem_q.wr;
  endsequence

  sequence s_idle_cycle;
    (state_q == cbbc_pkg::ST_IDLE) [*4];
  endsequence

  a_bc_taken_when_carry: assert property (@(posedge clk) disable iff (!arst_n)
    (quarter_q == cbbc_pkg::QP2 && is_bc && carry) |=> ##1 pc_wr_q)
    else $error("branch with carry set did not write the counter");

  a_bc_not_taken: assert property (@(posedge clk) disable iff (!arst_n)
    (quarter_q == cbbc_pkg::QP2 && !(is_bc && carry)) |=> ##1 !pc_wr_q)
    else $error("counter written without a taken branch");

  a_bc_target_math: assert property (@(posedge clk) disable iff (!arst_n)
    (quarter_q == cbbc_pkg::QP3 && taken_q)
      |=> pc_target_q == PC_W'($past(pc_next) + $past(offs_ext)))
    else $error("branch target is not pc_next plus twice the offset");

  a_bc_idle_after: assert property (@(posedge clk) disable iff (!arst_n)
    pc_wr_q |-> quarter_q == cbbc_pkg::QP4 ##1 s_idle_cycle)
    else $error("taken branch not followed by a full idle cycle");

  a_bcf_clears_bit: assert property (@(posedge clk) disable iff (!arst_n)
    mem_q.rd |-> ##2 mem_q.wr && mem_q.wdata == ($past(mem_rdata, 2) & ~clr_mask))
    else $error("clear-bit write-back changed the wrong bits");

  a_bcf_bank_select: assert property (@(posedge clk) disable iff (!arst_n)
    (quarter_q == cbbc_pkg::QP1 && state_q == cbbc_pkg::ST_EXEC && raw_bcf
      && instr[cbbc_pkg::ABIT])
      |=> mem_q.addr == {$past(bank_select_register), $past(instr[cbbc_pkg::LIT_HI:0])})
    else $error("banked address does not use the select register");

  a_bcf_indexed_mode: assert property (@(posedge clk) disable iff (!arst_n)
    (quarter_q == cbbc_pkg::QP1 && state_q == cbbc_pkg::ST_EXEC && raw_bcf
      && !instr[cbbc_pkg::ABIT] && ext_en && instr[cbbc_pkg::LIT_HI:0] <= cbbc_pkg::INDEXED_LIMIT)
      |=> mem_q.addr == cbbc_pkg::ADDR_W'($past(index_base) + $past(instr[cbbc_pkg::LIT_HI:0])))
    else $error("indexed literal offset address wrong");

  a_bcf_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    mem_q.rd |-> quarter_q == cbbc_pkg::QP2 ##0 s_rmw ##1 !mem_q.wr && !pc_wr_q)
    else $error("clear-bit did not finish in one instruction cycle");

endmodule // carry_branch_bit_clear_exec

// *** bench/mem_model.sv ***
// banked data memory model answering the executor's read and write pulses
`timescale 1ns/1ps
module mem_model #(
  parameter logic [7:0] INIT = 8'hC7
) (
  input  wire logic               clk,
  input  wire cbbc_pkg::mem_req_t req,
  output logic      [7:0]         rdata
);
  logic [7:0] cells [0:4095];
  logic [7:0] last_q;

  // every cell starts from the same known value so the bench can shadow it
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 4096; i++) cells[i] = INIT;
  end

  // write lands on the edge ending the write pulse; last read kept for the idle bus
  always @(posedge clk) begin
    if (req.wr) cells[req.addr] <= req.wdata;
    if (req.rd) last_q <= cells[req.addr];
  end

  // outside a read the bus shows the inverse of the last value, so stale data cannot match
  assign rdata = req.rd ? cells[req.addr] : ~last_q;
endmodule // mem_model

// *** bench/testbench.sv ***
// self-checking bench for the branch-on-carry and clear-bit executor
`timescale 1ns/1ps
module testbench;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic [15:0]           instr = 16'h0000;
  logic                  carry = 1'b1;
  logic [20:0]           pc_next = 21'h0;
  logic [3:0]            bank_select_register = 4'h3;
  logic                  ext_en = 1'b0;
  logic [11:0]           index_base = 12'h300;
  logic [7:0]            mem_rdata;
  cbbc_pkg::quarter_t    quarter_q;
  cbbc_pkg::exec_state_t state_q;
  logic                  pc_wr_q;
  logic [20:0]           pc_target_q;
  cbbc_pkg::mem_req_t    mem_q;
  logic [7:0]            shadow [0:4095];
  int                    num_errors = 0;
  int                    comparisons = 0;
  int                    npc, nrd, nwr;
  logic [20:0]           tgt;
  logic [11:0]           wa;
  logic [7:0]            wd;
  logic [1:0]            wq;

  carry_branch_bit_clear_exec dut_u (.clk(clk), .arst_n(arst_n), .instr(instr), .carry(carry),
    .pc_next(pc_next), .bank_select_register(bank_select_register), .ext_en(ext_en),
    .index_base(index_base), .mem_rdata(mem_rdata), .quarter_q(quarter_q), .state_q(state_q),
    .pc_wr_q(pc_wr_q), .pc_target_q(pc_target_q), .mem_q(mem_q));
  mem_model #(.INIT(8'hC7)) mem_u (.clk(clk), .req(mem_q), .rdata(mem_rdata));

  // 50 ns period, one clock per quarter phase
  always #25 clk = ~clk;

  task automatic finish_test();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for a fresh first quarter while executing
  task automatic sync();
    int i;
    for (i = 0; i < 8; i++) begin
      if (quarter_q === cbbc_pkg::QP1 && state_q === cbbc_pkg::ST_EXEC) break;
      @(posedge clk);
      #5;
    end
    if (i == 8) begin
      num_errors++;
      $display("CHECK FAILED t=%0t quarter wait ran out", $time);
      finish_test();
    end
  endtask

  // drive one word in Q1 and record the four quarters that follow
  task automatic exec(input logic [15:0] w);
    instr = w;
    wq = cbbc_pkg::QP1;
    npc = 0;
    nrd = 0;
    nwr = 0;
    repeat (4) begin
      @(posedge clk);
      #5;
      if (pc_wr_q === 1'b1) begin
        npc++;
        tgt = pc_target_q;
        wq = quarter_q;
      end
      if (mem_q.rd === 1'b1) nrd++;
      if (mem_q.wr === 1'b1) begin
        nwr++;
        wq = quarter_q;
        wa = mem_q.addr;
        wd = mem_q.wdata;
      end
    end
  endtask

  task automatic t_branch(input logic [7:0] off, input logic c);
    sync();
    carry = c;
    pc_next = 21'h1_2340;
    exec({8'hE2, off});
    check(npc, c);
    if (c) check(tgt, 21'(21'h1_2340 + {{12{off[7]}}, off, 1'b0}));
    if (c) check(wq, cbbc_pkg::QP4);
    check(state_q, c);
    if (c) begin
      // a word offered during the idle cycle must do nothing
      exec(16'h9E05);
      check(nrd + nwr + npc, 0);
    end
    check(state_q, cbbc_pkg::ST_EXEC);
    $display("branch test done off=%h carry=%b", off, c);
  endtask

  task automatic t_clear(input logic [2:0] b, input logic a, input logic [7:0] f, input logic x);
    logic [11:0] ea;
    logic [7:0]  ev;
    ea = a ? {bank_select_register, f} : (x && f <= 8'h5F) ? index_base + {4'h0, f}
       : {(f[7] ? 4'hF : 4'h0), f};
    ev = shadow[ea] & ~(8'h01 << b);
    shadow[ea] = ev;
    sync();
    ext_en = x;
    exec({4'h9, b, a, f});
    check(nrd, 1);
    check(nwr, 1);
    check(npc, 0);
    check(wa, ea);
    check(wd, ev);
    check(wq, cbbc_pkg::QP4);
    $display("clear test done bit=%0d a=%b f=%h ext=%b", b, a, f, x);
  endtask

  task automatic t_refuse(input logic [15:0] w);
    sync();
    carry = 1'b1;
    exec(w);
    check(npc + nrd + nwr, 0);
    $display("refuse test done word=%h", w);
  endtask

  // reset dropped in the write quarter of a taken branch; all state must clear at once
  task automatic t_reset();
    sync();
    carry = 1'b1;
    pc_next = 21'h1_2340;
    instr = 16'hE205;
    repeat (3) begin
      @(posedge clk);
      #5;
    end
    check(pc_wr_q, 1'b1);
    arst_n = 1'b0;
    #1;
    check(pc_wr_q, 1'b0);
    check(pc_target_q, 21'h0);
    check(quarter_q, cbbc_pkg::QP1);
    check(state_q, cbbc_pkg::ST_EXEC);
    check(mem_q, 32'h0);
    @(posedge clk);
    #4;
    arst_n = 1'b1;
    $display("reset test done");
  endtask

  // main sequence: reset for 16 clocks, then each scenario in turn
  initial begin
    for (int i = 0; i < 4096; i++) shadow[i] = 8'hC7;
    repeat (16) @(posedge clk);
    #5;
    arst_n = 1'b1;
    t_branch(8'h05, 1'b1);
    t_branch(8'h80, 1'b1);
    t_branch(8'h7F, 1'b1);
    t_branch(8'h05, 1'b0);
    for (int b = 0; b < 8; b++) t_clear(b[2:0], 1'b1, 8'h05, 1'b0);
    t_clear(3'h7, 1'b0, 8'h40, 1'b0);
    t_clear(3'h2, 1'b0, 8'hA0, 1'b1);
    t_clear(3'h1, 1'b0, 8'h5F, 1'b1);
    t_clear(3'h0, 1'b0, 8'h60, 1'b1);
    t_clear(3'h3, 1'b1, 8'h10, 1'b1);
    t_refuse(16'hE305);
    t_refuse(16'h8E05);
    t_reset();
    t_branch(8'h05, 1'b1);
    finish_test();
  end
endmodule // testbench
